// ---- hdl/sscfl_defs.vh ----
// constants for the switch command and fault logic
`ifndef SSCFL_DEFS_VH
`define SSCFL_DEFS_VH
`define SSCFL_FRAME_BITS     24
`define SSCFL_NOUT           16
`define SSCFL_CMD_MSB        23
`define SSCFL_CMD_LSB        18
`define SSCFL_CMD_ONOFF      6'h00
`define SSCFL_CMD_OLEN       6'h01
`define SSCFL_CMD_GLOBAL     6'h02
`define SSCFL_CMD_FSD        6'h03
`define SSCFL_CMD_PWMEN      6'h04
`define SSCFL_CMD_COMBINE    6'h05
`define SSCFL_CMD_RESET      6'h06
`define SSCFL_BIT_OV_RESTORE 16
`define SSCFL_BIT_TH_RETRY   17
`define SSCFL_BIT_ANY_FAULT  23
`define SSCFL_BIT_OV_FAULT   22
`define SSCFL_RST_ONOFF      16'h0000
`define SSCFL_RST_OLEN       16'h0000
`define SSCFL_RST_FSD        16'hffff
`define SSCFL_RST_PWMEN      16'h0000
`define SSCFL_RST_COMBINE    16'h0000
`define SSCFL_WRITE_GAP_US   450
`define SSCFL_CLK_MHZ        100
`define SSCFL_WRITE_GAP_CYC  (`SSCFL_WRITE_GAP_US * `SSCFL_CLK_MHZ)
`endif

// ---- hdl/sscfl_shift.v ----
// 24-bit spi shift register, msb first in and out
`timescale 1ns/100ps
`default_nettype none
`include "sscfl_defs.vh"
module sscfl_shift (
    // clock and reset
    input  wire        sys_clk_i,
    input  wire        resetn_i,
    // spi pins, sampled synchronously
    input  wire        cs_n_i,
    input  wire        sclk_i,
    input  wire        sdi_i,
    // parallel side and serial data out
    input  wire [23:0] load_word_i,
    output reg  [23:0] rx_word_o,
    output reg         sdo_o,
    output wire        frame_end_o,
    output wire        frame_start_o,
    output reg  [4:0]  bit_cnt_o
);
    reg        cs_d_reg;
    reg        sclk_d_reg;
    reg [23:0] tx_reg;
    wire       rise = sclk_i & ~sclk_d_reg;
    wire       fall = ~sclk_i & sclk_d_reg;

    assign frame_start_o = cs_d_reg & ~cs_n_i;
    assign frame_end_o   = ~cs_d_reg & cs_n_i;

    always @(posedge sys_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            cs_d_reg   <= 1'b1;
            sclk_d_reg <= 1'b0;
            tx_reg     <= 24'h000000;
            rx_word_o  <= 24'h000000;
            sdo_o      <= 1'b0;
            bit_cnt_o  <= 5'h00;
        end else begin
            cs_d_reg   <= cs_n_i;
            sclk_d_reg <= sclk_i;
            if (frame_start_o) begin
                // fault word captured at chip select fall
                tx_reg    <= {load_word_i[22:0], 1'b0};
                sdo_o     <= load_word_i[23];
                bit_cnt_o <= 5'h00;
            end else if (!cs_n_i && rise) begin
                rx_word_o <= {rx_word_o[22:0], sdi_i};
                if (bit_cnt_o != 5'h1f)
                    bit_cnt_o <= bit_cnt_o + 5'h01;
            end else if (!cs_n_i && fall) begin
                sdo_o  <= tx_reg[23];
                tx_reg <= {tx_reg[22:0], 1'b0};
            end
        end
    end
endmodule
`default_nettype wire

// ---- hdl/sscfl_top.v ----
// command interpreter and fault reporting for a 16-output switch
// Functional notes
// - combine bit 0: output is pwm AND spi on bit
// - combine bit 1: output is pwm OR spi on bit
// - shifted-out bit 1 means fault, 0 means none
// - latched fault bits clear on chip select rise
// - fault word bits 15..0 are per-output faults
// - fault word bits 21..16 read zero
// - bit 22 overvoltage, bit 23 any fault
// - reset command turns outputs off, registers to power-on values, except the write gap counter, which restarts its full span
// - every frame is exactly 24 bits both ways
// - command and fault words shift msb first
// - on/off field: 0 off, 1 on
// - overtemperature shuts only that output; retry or latch per thermal bit
// - overcurrent flagged; reaching thermal limit applies thermal policy
// - open load flagged only while commanded off
// - overvoltage shuts all; recovery restores or keeps off per bit
// - bits 23..18 select one of seven commands
// - command acts only at chip select rise
// - pwm enable routes common pwm; else spi bit with parallel input
// - bit 16 overvoltage recovery, bit 17 thermal retry
`timescale 1ns/100ps
`default_nettype none
`include "sscfl_defs.vh"
module sscfl_top (
    // clock and reset
    input  wire        sys_clk_i,
    input  wire        resetn_i,
    // spi link
    input  wire        cs_n_i,
    input  wire        sclk_i,
    input  wire        sdi_i,
    output wire        sdo_o,
    // pwm inputs
    input  wire        common_pwm_i,
    input  wire [15:0] parallel_pulse_input_i,
    // analog sense inputs, one per output except the shared overvoltage input
    input  wire [15:0] over_temp_i,
    input  wire [15:0] over_current_i,
    input  wire [15:0] open_load_i,
    input  wire [15:0] fast_short_i,
    input  wire        over_voltage_i,
    // drivers, analog controls and write gap flag
    output reg  [15:0] driver_output_o,
    output wire [15:0] open_load_current_en_o,
    output wire [15:0] fast_short_disable_o,
    output wire        write_gap_ok_o
);
    localparam [2:0] ST_NORMAL = 3'b001;
    localparam [2:0] ST_OVSHUT = 3'b010;
    localparam [2:0] ST_OVOFF  = 3'b100;
    // write gap span in clock cycles, fits the 17-bit counter
    localparam [16:0] GAP_CYC  = `SSCFL_WRITE_GAP_CYC;

    reg  [15:0] onoff_reg;
    reg  [15:0] olen_reg;
    reg  [15:0] fast_short_disable_reg;
    reg  [15:0] pwmen_reg;
    reg  [15:0] pwm_combine_select_reg;
    reg         ov_restore_reg;
    reg         th_retry_reg;
    reg  [15:0] fault_reg;
    reg         ov_fault_reg;
    reg  [15:0] th_latch_reg;
    reg  [2:0]  ov_state_reg;
    reg  [2:0]  ov_state_next;
    reg  [15:0] fast_off_reg;
    reg  [15:0] drive_next;
    wire [15:0] combined;
    reg  [15:0] fault_next;
    reg  [15:0] th_latch_next;
    reg  [15:0] onoff_next;
    reg  [15:0] olen_next;
    reg  [15:0] fsd_next;
    reg  [15:0] pwmen_next;
    reg  [15:0] comb_next;
    reg         ovr_next;
    reg         thr_next;
    reg         ov_fault_next;
    reg         do_reset;
    reg  [16:0] gap_cnt_reg;
    wire [23:0] rx_word;
    wire        frame_end;
    wire        frame_start;
    wire [4:0]  bit_cnt;
    wire [23:0] fault_word;
    wire [5:0]  cmd;

    sscfl_shift u_shift (
        .sys_clk_i     (sys_clk_i),
        .resetn_i      (resetn_i),
        .cs_n_i        (cs_n_i),
        .sclk_i        (sclk_i),
        .sdi_i         (sdi_i),
        .load_word_i   (fault_word),
        .rx_word_o     (rx_word),
        .sdo_o         (sdo_o),
        .frame_end_o   (frame_end),
        .frame_start_o (frame_start),
        .bit_cnt_o     (bit_cnt)
    );

    // decoded code is valid only for the seven defined commands
    function cmd_known;
        input [5:0] c;
        begin
            cmd_known = (c <= `SSCFL_CMD_RESET);
        end
    endfunction

    assign cmd = rx_word[`SSCFL_CMD_MSB:`SSCFL_CMD_LSB];
    // 1 flags a fault, reserved bits zero
    assign fault_word = {(ov_fault_reg | (|fault_reg)), ov_fault_reg,
                         6'h00, fault_reg};
    assign open_load_current_en_o = olen_reg;
    assign fast_short_disable_o   = fast_short_disable_reg;
    assign write_gap_ok_o = (gap_cnt_reg == 17'h00000);

    // per-output pwm merge
    genvar g;
    generate
        for (g = 0; g < `SSCFL_NOUT; g = g + 1) begin : g_out
            assign combined[g] = !pwmen_reg[g] ? (onoff_reg[g] | parallel_pulse_input_i[g])
                               : pwm_combine_select_reg[g] ? (common_pwm_i | onoff_reg[g])
                               : (common_pwm_i & onoff_reg[g]);
        end
    endgenerate

    // accepted frame: full 24 bits, ends on chip select rise
    always @* begin
        onoff_next = onoff_reg;
        olen_next  = olen_reg;
        fsd_next   = fast_short_disable_reg;
        pwmen_next = pwmen_reg;
        comb_next  = pwm_combine_select_reg;
        ovr_next   = ov_restore_reg;
        thr_next   = th_retry_reg;
        do_reset   = 1'b0;
        if (frame_end && bit_cnt == 5'h18 && cmd_known(cmd)) begin
            case (cmd)
                `SSCFL_CMD_ONOFF:   onoff_next = rx_word[15:0];
                `SSCFL_CMD_OLEN:    olen_next  = rx_word[15:0];
                `SSCFL_CMD_GLOBAL: begin
                    ovr_next = rx_word[`SSCFL_BIT_OV_RESTORE];
                    thr_next = rx_word[`SSCFL_BIT_TH_RETRY];
                end
                `SSCFL_CMD_FSD:     fsd_next   = rx_word[15:0];
                `SSCFL_CMD_PWMEN:   pwmen_next = rx_word[15:0];
                `SSCFL_CMD_COMBINE: comb_next  = rx_word[15:0];
                `SSCFL_CMD_RESET:   do_reset   = 1'b1;
                default:            do_reset   = 1'b0;
            endcase
        end
    end

    // overvoltage supervisor
    always @* begin
        ov_state_next = ov_state_reg;
        case (ov_state_reg)
            ST_NORMAL: if (over_voltage_i) ov_state_next = ST_OVSHUT;
            ST_OVSHUT: if (!over_voltage_i)
                ov_state_next = ov_restore_reg ? ST_NORMAL : ST_OVOFF;
            ST_OVOFF:  if (over_voltage_i) ov_state_next = ST_OVSHUT;
            default:   ov_state_next = ST_NORMAL;
        endcase
    end

    // fault capture and output gating
    always @* begin
        th_latch_next = th_latch_reg;
        // latched off unless retry selected; cleared once cooled with retry
        th_latch_next = (th_latch_reg & {16{~th_retry_reg}}) | over_temp_i;
        fault_next = over_temp_i | over_current_i
                   | (open_load_i & ~onoff_reg & olen_reg);
        drive_next = combined & ~th_latch_reg & ~over_temp_i & ~fast_off_reg;
        if (ov_state_reg != ST_NORMAL || over_voltage_i)
            drive_next = 16'h0000;
        ov_fault_next = over_voltage_i;
    end

    always @(posedge sys_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            onoff_reg              <= `SSCFL_RST_ONOFF;
            olen_reg               <= `SSCFL_RST_OLEN;
            fast_short_disable_reg <= `SSCFL_RST_FSD;
            pwmen_reg              <= `SSCFL_RST_PWMEN;
            pwm_combine_select_reg <= `SSCFL_RST_COMBINE;
            ov_restore_reg         <= 1'b0;
            th_retry_reg           <= 1'b0;
            fault_reg              <= 16'h0000;
            ov_fault_reg           <= 1'b0;
            th_latch_reg           <= 16'h0000;
            fast_off_reg           <= 16'h0000;
            ov_state_reg           <= ST_NORMAL;
            driver_output_o        <= 16'h0000;
            gap_cnt_reg            <= 17'h00000;
        end else if (do_reset) begin
            onoff_reg              <= `SSCFL_RST_ONOFF;
            olen_reg               <= `SSCFL_RST_OLEN;
            fast_short_disable_reg <= `SSCFL_RST_FSD;
            pwmen_reg              <= `SSCFL_RST_PWMEN;
            pwm_combine_select_reg <= `SSCFL_RST_COMBINE;
            ov_restore_reg         <= 1'b0;
            th_retry_reg           <= 1'b0;
            fault_reg              <= 16'h0000;
            ov_fault_reg           <= 1'b0;
            th_latch_reg           <= 16'h0000;
            fast_off_reg           <= 16'h0000;
            ov_state_reg           <= ST_NORMAL;
            driver_output_o        <= 16'h0000;
            gap_cnt_reg            <= GAP_CYC;
        end else begin
            onoff_reg              <= onoff_next;
            olen_reg               <= olen_next;
            fast_short_disable_reg <= fsd_next;
            pwmen_reg              <= pwmen_next;
            pwm_combine_select_reg <= comb_next;
            ov_restore_reg         <= ovr_next;
            th_retry_reg           <= thr_next;
            ov_state_reg           <= ov_state_next;
            th_latch_reg           <= th_latch_next;
            driver_output_o        <= drive_next;
            // fast short off only where not disabled; cleared when an on/off write changes the on/off bits
            if (onoff_next != onoff_reg)
                fast_off_reg <= fast_short_i & ~fast_short_disable_reg;
            else
                fast_off_reg <= fast_off_reg | (fast_short_i & ~fast_short_disable_reg);
            // sticky faults: new fault wins over the clear at chip select rise
            if (frame_end) begin
                fault_reg    <= fault_next;
                ov_fault_reg <= ov_fault_next;
            end else begin
                fault_reg    <= fault_reg | fault_next;
                ov_fault_reg <= ov_fault_reg | ov_fault_next;
            end
            if (frame_end)
                gap_cnt_reg <= GAP_CYC;
            else if (gap_cnt_reg != 17'h00000)
                gap_cnt_reg <= gap_cnt_reg - 17'h00001;
        end
    end
endmodule
`default_nettype wire

// ---- test/spi_switch_command_fault_logic_tb.sv ----
// self-checking bench for the switch command and fault logic
`timescale 1ns/100ps
`default_nettype none
module spi_switch_command_fault_logic_tb;
    logic        sys_clk_i;
    logic        resetn_i;
    logic        cs_n, sclk, sdi, sdo, gap_ok;
    logic        pwm;
    logic        ov;
    logic [15:0] par, ot, oc, ol, fs;
    logic [15:0] drv, olen, fsd;
    logic [23:0] rsp;
    int          errors = 0;
    int          n_tests = 0;
    always #5 sys_clk_i = ~sys_clk_i;
    sscfl_host sscfl_host_i (.clk_i(sys_clk_i), .cs_n_o(cs_n), .sclk_o(sclk), .sdi_o(sdi),
        .sdo_i(sdo));
    sscfl_top sscfl_top_i (.sys_clk_i(sys_clk_i), .resetn_i(resetn_i), .cs_n_i(cs_n),
        .sclk_i(sclk), .sdi_i(sdi), .sdo_o(sdo), .common_pwm_i(pwm),
        .parallel_pulse_input_i(par), .over_temp_i(ot), .over_current_i(oc),
        .open_load_i(ol), .fast_short_i(fs), .over_voltage_i(ov),
        .driver_output_o(drv), .open_load_current_en_o(olen),
        .fast_short_disable_o(fsd), .write_gap_ok_o(gap_ok));
    task automatic chk(input string what, input logic [23:0] seen, input logic [23:0] exp);
        n_tests++;
        if (seen !== exp) begin
            errors++;
            $display("Error %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic cmd(input logic [23:0] w);
        sscfl_host_i.xfer(w, rsp);
        sscfl_host_i.step(3);
    endtask
    task automatic t_reset;
        chk("drv", 24'(drv), 24'h0);
        chk("fsd", 24'(fsd), 24'hffff);
        chk("olen", 24'(olen), 24'h0);
        chk("gap", 24'(gap_ok), 24'h1);
    endtask
    task automatic t_combine;
        cmd(24'h10ffff);
        cmd(24'h00a5a5);
        chk("gap", 24'(gap_ok), 24'h0);
        pwm = 1'b1;
        sscfl_host_i.step(3);
        chk("and1", 24'(drv), 24'ha5a5);
        pwm = 1'b0;
        sscfl_host_i.step(3);
        chk("and0", 24'(drv), 24'h0);
        cmd(24'h1400ff);
        chk("or0", 24'(drv), 24'h00a5);
        pwm = 1'b1;
        sscfl_host_i.step(3);
        chk("or1", 24'(drv), 24'ha5ff);
    endtask
    task automatic t_parallel;
        cmd(24'h100000);
        par = 16'h0f00;
        sscfl_host_i.step(3);
        chk("par", 24'(drv), 24'hafa5);
        par = 16'h0000;
        cmd(24'h1c0000);
        cmd(24'hfc0000);
        chk("bad", 24'(drv), 24'ha5a5);
        chk("badf", 24'(fsd), 24'hffff);
    endtask
    task automatic t_faults;
        oc = 16'h0020;
        sscfl_host_i.step(3);
        cmd(24'h1c0000);
        chk("oc", rsp, 24'h800020);
        oc = 16'h0000;
        cmd(24'h1c0000);
        chk("sticky", rsp, 24'h800020);
        cmd(24'h1c0000);
        chk("clear", rsp, 24'h000000);
        cmd(24'h090000);
        ov = 1'b1;
        sscfl_host_i.step(4);
        chk("ovoff", 24'(drv), 24'h0);
        cmd(24'h1c0000);
        chk("ovword", rsp, 24'hc00000);
        ov = 1'b0;
        sscfl_host_i.step(4);
        chk("ovback", 24'(drv), 24'ha5a5);
        ot = 16'h0004;
        sscfl_host_i.step(4);
        chk("hot", 24'(drv), 24'ha5a1);
        ot = 16'h0000;
        sscfl_host_i.step(4);
        chk("latch", 24'(drv), 24'ha5a1);
        cmd(24'h0a0000);
        chk("retry", 24'(drv), 24'ha5a5);
    endtask
    task automatic t_open_reset;
        cmd(24'h04ffff);
        chk("olen", 24'(olen), 24'hffff);
        ol = 16'h0300;
        cmd(24'h000100);
        cmd(24'h1c0000);
        chk("open", 24'(rsp[9:8]), 24'h2);
        ol = 16'h0000;
        cmd(24'h0c0000);
        chk("fsd0", 24'(fsd), 24'h0);
        chk("fson", 24'(drv), 24'h0100);
        fs = 16'h0100;
        sscfl_host_i.step(3);
        fs = 16'h0000;
        sscfl_host_i.step(3);
        chk("fsoff", 24'(drv), 24'h0);
        cmd(24'h180000);
        chk("rdrv", 24'(drv), 24'h0);
        chk("rfsd", 24'(fsd), 24'hffff);
        chk("rolen", 24'(olen), 24'h0);
        cmd(24'h000001);
        chk("on0", 24'(drv), 24'h0001);
        ov = 1'b1;
        sscfl_host_i.step(4);
        ov = 1'b0;
        sscfl_host_i.step(4);
        chk("ovkeep", 24'(drv), 24'h0);
    endtask
    task automatic complete_run;
        $display("checks %0d errors %0d", n_tests, errors);
        if (errors == 0 && n_tests > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask
    initial begin
        #400000;
        errors++;
        complete_run();
    end
    initial begin
        sys_clk_i = 1'b0;
        resetn_i  = 1'b0;
        pwm       = 1'b0;
        ov        = 1'b0;
        par       = 16'h0000;
        ot        = 16'h0000;
        oc        = 16'h0000;
        ol        = 16'h0000;
        fs        = 16'h0000;
        repeat (5) @(posedge sys_clk_i);
        #1 resetn_i = 1'b1;
        sscfl_host_i.step(2);
        t_reset();
        t_combine();
        t_parallel();
        t_faults();
        t_open_reset();
        complete_run();
    end
endmodule
`default_nettype wire

// ---- test/sscfl_host.sv ----
// spi master model standing in for the host controller
`timescale 1ns/100ps
`default_nettype none
module sscfl_host (
    input  wire logic clk_i,
    output var logic  cs_n_o,
    output var logic  sclk_o,
    output var logic  sdi_o,
    input  wire logic sdo_i
);
    initial begin
        cs_n_o = 1'b1;
        sclk_o = 1'b0;
        sdi_o  = 1'b0;
    end
    task automatic step(input int n);
        repeat (n) @(posedge clk_i);
        #1;
    endtask
    // one whole frame, sdi set while sclk low, sdo taken at sclk rise
    task automatic xfer(input logic [23:0] cmd, output logic [23:0] rsp);
        int i;
        cs_n_o = 1'b0;
        step(3);
        for (i = 23; i >= 0; i--) begin
            sdi_o = cmd[i];
            step(3);
            sclk_o = 1'b1;
            rsp[i] = sdo_i;
            step(3);
            sclk_o = 1'b0;
        end
        step(3);
        cs_n_o = 1'b1;
        sdi_o = ~sdi_o;
        step(3);
    endtask
endmodule
`default_nettype wire

// ---- test/sscfl_monitor.sv ----
// port-level checks on the switch command and fault logic
`timescale 1ns/100ps
`default_nettype none
module sscfl_monitor (
    input wire logic        sys_clk_i,
    input wire logic        resetn_i,
    input wire logic        cs_n_i,
    input wire logic        sclk_i,
    input wire logic        sdo_o,
    input wire logic [15:0] over_temp_i,
    input wire logic        over_voltage_i,
    input wire logic [15:0] driver_output_o,
    input wire logic [15:0] open_load_current_en_o,
    input wire logic [15:0] fast_short_disable_o,
    input wire logic        write_gap_ok_o
);
    default clocking @(posedge sys_clk_i); endclocking
    default disable iff (!resetn_i);
    logic       sclk_q;
    logic       ov_cap;
    logic [4:0] rises;
    wire        rise = sclk_i && !sclk_q && !cs_n_i;
    // count sclk rises in a frame; hold overvoltage as seen at cs fall
    always @(posedge sys_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            sclk_q <= 1'b0;
            ov_cap <= 1'b0;
            rises  <= 5'h00;
        end else begin
            sclk_q <= sclk_i;
            if (cs_n_i) ov_cap <= over_voltage_i;
            if (cs_n_i) rises <= 5'h00;
            else if (rise) rises <= rises + 5'h01;
        end
    end
    a_regs_frozen: assert property (!cs_n_i && !$past(cs_n_i) |->
        $stable(open_load_current_en_o) && $stable(fast_short_disable_o))
        else $error("control register changed inside a frame");
    a_upper_zero: assert property (rise && rises >= 5'h02 && rises <= 5'h07 |-> !sdo_o)
        else $error("fault word bit 21..16 not zero");
    a_ov_flag: assert property (rise && rises == 5'h01 && ov_cap |-> sdo_o)
        else $error("overvoltage bit not set");
    a_any_fault: assert property (rise && rises == 5'h00 && ov_cap |-> sdo_o)
        else $error("any-fault bit not set");
    a_ov_shutdown: assert property (over_voltage_i [*4] |-> driver_output_o == 16'h0000)
        else $error("outputs on during overvoltage");
    a_hot_off: assert property ((over_temp_i == $past(over_temp_i)) [*4] |->
        (driver_output_o & over_temp_i) == 16'h0000)
        else $error("hot output still on");
    a_gap_drop: assert property ($rose(cs_n_i) |-> ##[1:3] !write_gap_ok_o)
        else $error("write gap flag not cleared");
    a_gap_hold: assert property ($fell(write_gap_ok_o) |=> !write_gap_ok_o [*8])
        else $error("write gap flag returned early");
    c_frame: cover property ($rose(cs_n_i));
    c_ov_frame: cover property (rise && ov_cap);
    c_hot: cover property (over_temp_i != 16'h0000);
endmodule
bind sscfl_top sscfl_monitor sscfl_monitor_i (
    .sys_clk_i(sys_clk_i), .resetn_i(resetn_i), .cs_n_i(cs_n_i), .sclk_i(sclk_i),
    .sdo_o(sdo_o), .over_temp_i(over_temp_i), .over_voltage_i(over_voltage_i),
    .driver_output_o(driver_output_o), .open_load_current_en_o(open_load_current_en_o),
    .fast_short_disable_o(fast_short_disable_o), .write_gap_ok_o(write_gap_ok_o));
`default_nettype wire
